/* File: rtl/urps_port.sv */
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module urps_port
   import urps_pkg::*;
#(
   parameter int RESUME_CYCLES = URPS_RESUME_CYCLES,
   parameter int CNT_W         = 20
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire urps_pkg::urps_bus_s  bus,
   output logic [31:0]               rdata,
   input  wire urps_pkg::urps_pins_s pins,
   input  wire urps_pkg::urps_hc_s   hc,
   output logic                      port_suspend,
   output logic                      port_enabled,
   output logic                      resume_drive,
   output logic                      resume_to_hc,
   output logic                      irq
);

   import urps_pkg::*;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   urps_pins_s pins_s;

   urps_sync #(
      .WIDTH    (3)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in (pins),
      .sync_out (pins_s)
   );

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   urps_state_e      state;
   urps_state_e      next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic             port_enabled_flag;
   logic             next_enabled;
   logic [4:0]       chg;
   logic [4:0]       next_chg;
   logic [4:0]       mask;
   logic [4:0]       next_mask;
   logic             removable_device_mask;
   logic             next_removable;
   logic             conn_q;
   logic             oc_q;
   logic             next_resume_to_hc;
   logic [31:0]      next_rdata;

   logic             port_suspended_flag;
   logic             device_connected_flag;
   logic             connected;
   logic             wr_status;
   logic             wr_mask;
   logic             wr_cfg;
   logic             fault;
   logic             resume_done;
   logic             w_clr_en;
   logic             w_set_en;
   logic             w_set_susp;
   logic             w_resume;

   localparam logic [CNT_W-1:0] RESUME_LAST = CNT_W'(RESUME_CYCLES - 1);

   // -------------------------------------------------------------
   // Decode and derived terms
   // -------------------------------------------------------------
   // A non-removable device counts as attached for all port logic
   assign connected             = pins_s.attach | removable_device_mask;
   assign device_connected_flag = connected;
   assign port_suspended_flag   = (state != st_active);

   assign wr_status  = bus.wr && (bus.addr == URPS_OFS_STATUS);
   assign wr_mask    = bus.wr && (bus.addr == URPS_OFS_MASK);
   assign wr_cfg     = bus.wr && (bus.addr == URPS_OFS_CONFIG);
   assign w_clr_en   = wr_status && bus.wdata[URPS_B_CONNECTED];
   assign w_set_en   = wr_status && bus.wdata[URPS_B_ENABLED];
   assign w_set_susp = wr_status && bus.wdata[URPS_B_SUSPENDED];
   assign w_resume   = wr_status && bus.wdata[URPS_B_RESUME];

   assign resume_done = (state == st_resuming) && (count == RESUME_LAST);

   // Any hardware reason to drop the port off the bus
   assign fault = (pins_s.overcurrent & ~oc_q) | (conn_q & ~connected)
                | ~hc.power_on | hc.babble;

   // -------------------------------------------------------------
   // Suspend / resume sequencer
   // -------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_count        = '0;
      next_resume_to_hc = 1'b0;
      unique case (state)
         st_active: begin
            if (w_set_susp && connected) begin
               next_state = st_suspended;
            end
         end
         st_suspended: begin
            if (pins_s.upstream_resume) begin
               next_state        = st_resuming;
               next_resume_to_hc = 1'b1;
            end else if (w_resume) begin
               next_state = st_resuming;
            end
         end
         st_resuming: begin
            next_count = count + CNT_W'(1);
            if (resume_done) begin
               next_state = st_active;
               next_count = '0;
            end
         end
      endcase
      // Reset completion, host resume and loss of device abort the sequence
      if (hc.reset_done || hc.host_resume_state || !connected || !hc.power_on) begin
         next_state        = st_active;
         next_count        = '0;
         next_resume_to_hc = 1'b0;
      end
      // Suspend cannot take hold with no device
      if (!connected) begin
         next_state = st_active;
      end
   end

   // -------------------------------------------------------------
   // Enable flag
   // -------------------------------------------------------------
   always_comb begin
      next_enabled = port_enabled_flag;
      if ((w_set_en || hc.reset_done || resume_done) && connected) begin
         next_enabled = 1'b1;
      end
      if (fault || !connected) begin
         next_enabled = 1'b0;
      end
      // Software clear wins over every set in the same cycle
      if (w_clr_en) begin
         next_enabled = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Change flags, mask and configuration
   // -------------------------------------------------------------
   always_comb begin
      logic [4:0] set_bits;
      logic [4:0] clr_bits;
      set_bits = '0;
      clr_bits = '0;
      if (wr_status) begin
         clr_bits = bus.wdata[URPS_B_CHG_LO +: URPS_CHG_W];
      end
      if (conn_q != connected) begin
         set_bits[URPS_C_CONN] = 1'b1;
      end
      if ((w_set_en || w_set_susp) && !connected) begin
         set_bits[URPS_C_CONN] = 1'b1;
      end
      if (fault && port_enabled_flag && !w_clr_en) begin
         set_bits[URPS_C_ENABLE] = 1'b1;
      end
      if (resume_done) begin
         set_bits[URPS_C_SUSPEND] = 1'b1;
      end
      if (pins_s.overcurrent != oc_q) begin
         set_bits[URPS_C_OVERCUR] = 1'b1;
      end
      if (hc.reset_done) begin
         set_bits[URPS_C_RESET] = 1'b1;
      end
      // A new event in the clearing cycle is kept
      next_chg       = (chg & ~clr_bits) | set_bits;
      next_mask      = wr_mask ? bus.wdata[URPS_B_CHG_LO +: URPS_CHG_W] : mask;
      next_removable = wr_cfg ? bus.wdata[URPS_B_NONREM] : removable_device_mask;
   end

   // -------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      if (bus.rd) begin
         unique case (bus.addr)
            URPS_OFS_STATUS: begin
               next_rdata[URPS_B_CONNECTED] = device_connected_flag;
               next_rdata[URPS_B_ENABLED]   = port_enabled_flag;
               next_rdata[URPS_B_SUSPENDED] = port_suspended_flag;
               next_rdata[URPS_B_CHG_LO +: URPS_CHG_W] = chg;
            end
            URPS_OFS_MASK: begin
               next_rdata[URPS_B_CHG_LO +: URPS_CHG_W] = mask;
            end
            URPS_OFS_CONFIG: begin
               next_rdata[URPS_B_NONREM] = removable_device_mask;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state                 <= st_active;
         count                 <= '0;
         port_enabled_flag     <= 1'b0;
         chg                   <= URPS_CHG_RST;
         mask                  <= URPS_MASK_RST;
         removable_device_mask <= URPS_CFG_RST;
         conn_q                <= 1'b0;
         oc_q                  <= 1'b0;
         resume_to_hc          <= 1'b0;
         rdata                 <= '0;
      end else begin
         state                 <= next_state;
         count                 <= next_count;
         port_enabled_flag     <= next_enabled;
         chg                   <= next_chg;
         mask                  <= next_mask;
         removable_device_mask <= next_removable;
         conn_q                <= connected;
         oc_q                  <= pins_s.overcurrent;
         resume_to_hc          <= next_resume_to_hc;
         rdata                 <= next_rdata;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Resume drive stays on for the whole resume interval; port_suspend only while suspended
   assign port_suspend = (state == st_suspended);
   assign resume_drive = (state == st_resuming);
   assign port_enabled = port_enabled_flag;
   assign irq          = |(chg & mask);

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_susp_needs_conn;
      @(posedge core_clk) disable iff (reset)
      $rose(port_suspended_flag) |-> $past(connected);
   endproperty
   a_susp_needs_conn: assert property (p_susp_needs_conn)
      else $error("suspend set without a device");

   property p_enable_needs_conn;
      @(posedge core_clk) disable iff (reset)
      $rose(port_enabled_flag) |-> $past(connected);
   endproperty
   a_enable_needs_conn: assert property (p_enable_needs_conn)
      else $error("enable set without a device");

   property p_susp_disconnected;
      @(posedge core_clk) disable iff (reset)
      w_set_susp && !connected && !port_suspended_flag
      |=> chg[URPS_C_CONN] && !port_suspended_flag;
   endproperty
   a_susp_disconnected: assert property (p_susp_disconnected)
      else $error("suspend write on empty port mishandled");

   property p_sw_clear_enable;
      @(posedge core_clk) disable iff (reset)
      w_clr_en |=> !port_enabled_flag;
   endproperty
   a_sw_clear_enable: assert property (p_sw_clear_enable)
      else $error("enable survived a clear write");

   property p_fault_change;
      @(posedge core_clk) disable iff (reset)
      $fell(port_enabled_flag) && !$past(w_clr_en) |-> chg[URPS_C_ENABLE];
   endproperty
   a_fault_change: assert property (p_fault_change)
      else $error("enable dropped without enable change");

   property p_reset_clears_susp;
      @(posedge core_clk) disable iff (reset)
      hc.reset_done |=> !port_suspended_flag && chg[URPS_C_RESET];
   endproperty
   a_reset_clears_susp: assert property (p_reset_clears_susp)
      else $error("reset completion left port suspended");

   property p_resume_end;
      @(posedge core_clk) disable iff (reset)
      resume_done && connected && hc.power_on && !w_clr_en && !fault
      |=> chg[URPS_C_SUSPEND] && !port_suspended_flag && port_enabled_flag;
   endproperty
   a_resume_end: assert property (p_resume_end)
      else $error("resume end did not restore the port");

   property p_upstream_resume;
      @(posedge core_clk) disable iff (reset)
      resume_to_hc |-> $past(state) == st_suspended && resume_drive;
   endproperty
   a_upstream_resume: assert property (p_upstream_resume)
      else $error("resume forwarded from wrong state");

   property p_nonremovable_read;
      @(posedge core_clk) disable iff (reset)
      bus.rd && bus.addr == URPS_OFS_STATUS && removable_device_mask
      |=> rdata[URPS_B_CONNECTED];
   endproperty
   a_nonremovable_read: assert property (p_nonremovable_read)
      else $error("non-removable port read as empty");

   property p_connect_mirror;
      @(posedge core_clk) disable iff (reset)
      bus.rd && bus.addr == URPS_OFS_STATUS
      |=> rdata[URPS_B_CONNECTED] == $past(connected);
   endproperty
   a_connect_mirror: assert property (p_connect_mirror)
      else $error("connected flag does not mirror the port");

   property p_set_enable;
      @(posedge core_clk) disable iff (reset)
      w_set_en && connected && !fault && !w_clr_en |=> port_enabled_flag;
   endproperty
   a_set_enable: assert property (p_set_enable)
      else $error("enable write ignored");

   property p_susp_read;
      @(posedge core_clk) disable iff (reset)
      bus.rd && bus.addr == URPS_OFS_STATUS
      |=> rdata[URPS_B_SUSPENDED] == ($past(state) != st_active);
   endproperty
   a_susp_read: assert property (p_susp_read)
      else $error("suspended flag wrong on read");

endmodule

`default_nettype wire

/* File: rtl/urps_pkg.sv */
package urps_pkg;

   // -------------------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [3:0] URPS_OFS_STATUS = 4'h0;
   localparam logic [3:0] URPS_OFS_MASK   = 4'h4;
   localparam logic [3:0] URPS_OFS_CONFIG = 4'h8;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int URPS_B_CONNECTED = 0;
   localparam int URPS_B_ENABLED   = 1;
   localparam int URPS_B_SUSPENDED = 2;
   localparam int URPS_B_RESUME    = 3;
   localparam int URPS_B_CHG_LO    = 16;
   localparam int URPS_CHG_W       = 5;
   localparam int URPS_C_CONN      = 0;
   localparam int URPS_C_ENABLE    = 1;
   localparam int URPS_C_SUSPEND   = 2;
   localparam int URPS_C_OVERCUR   = 3;
   localparam int URPS_C_RESET     = 4;
   localparam int URPS_B_NONREM    = 0;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [4:0] URPS_CHG_RST  = 5'h00;
   localparam logic [4:0] URPS_MASK_RST = 5'h00;
   localparam logic       URPS_CFG_RST  = 1'b0;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int URPS_RESUME_MS     = 20;
   localparam int URPS_CLK_KHZ       = 40000;
   localparam int URPS_RESUME_CYCLES = URPS_RESUME_MS * URPS_CLK_KHZ;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum {
      st_active,
      st_suspended,
      st_resuming
   } urps_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } urps_bus_s;

   typedef struct packed {
      logic attach;
      logic overcurrent;
      logic upstream_resume;
   } urps_pins_s;

   typedef struct packed {
      logic power_on;
      logic reset_done;
      logic babble;
      logic host_resume_state;
   } urps_hc_s;

endpackage

/* File: rtl/urps_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module urps_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

`default_nettype wire

/* File: test/urps_dev.sv */
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------
// Downstream device attached to the root port
// -------------------------------------------------------------
module urps_dev
   import urps_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 plugged,
   input  wire logic                 fault,
   input  wire logic                 wake,
   input  wire logic                 port_suspend,
   input  wire logic                 resume_drive,
   output var  urps_pkg::urps_pins_s pins
);
   logic signalling;
   logic next_signalling;

   // Remote wakeup only while the bus sits suspended; the device lets go once the host drives resume
   always_comb begin
      next_signalling = signalling;
      if (resume_drive) begin
         next_signalling = 1'b0;
      end else if (wake && port_suspend && plugged) begin
         next_signalling = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         signalling <= 1'b0;
      end else begin
         signalling <= next_signalling;
      end
   end

   always_comb begin
      pins.attach          = plugged;
      pins.overcurrent     = fault;
      pins.upstream_resume = signalling;
   end
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import urps_pkg::*;

   // Short resume interval keeps the run brief
   localparam int          RES  = 16;
   localparam logic [31:0] CON  = 32'h1;
   localparam logic [31:0] EN   = 32'h2;
   localparam logic [31:0] SUS  = 32'h4;
   localparam logic [31:0] RSM  = 32'h8;
   localparam logic [31:0] CHC  = 32'h10000;
   localparam logic [31:0] CHE  = 32'h20000;
   localparam logic [31:0] CHS  = 32'h40000;
   localparam logic [31:0] CHR  = 32'h100000;
   localparam logic [31:0] ALLC = 32'h1F0000;
   localparam logic [31:0] ALL  = 32'h1F0007;

   logic        core_clk;
   logic        reset;
   urps_bus_s   bus;
   logic [31:0] rdata;
   urps_pins_s  pins;
   urps_hc_s    hc;
   logic        port_suspend;
   logic        port_enabled;
   logic        resume_drive;
   logic        resume_to_hc;
   logic        irq;
   logic        plugged;
   logic        fault;
   logic        wake;
   logic [31:0] v;
   int          n_errors;
   int          checks_done;

   urps_port #(.RESUME_CYCLES(RES), .CNT_W(20)) uut (
      .core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata), .pins(pins), .hc(hc),
      .port_suspend(port_suspend), .port_enabled(port_enabled), .resume_drive(resume_drive),
      .resume_to_hc(resume_to_hc), .irq(irq));

   urps_dev dev (
      .core_clk(core_clk), .reset(reset), .plugged(plugged), .fault(fault), .wake(wake),
      .port_suspend(port_suspend), .resume_drive(resume_drive), .pins(pins));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // -------------------------------------------------------------
   // Bus cycles and comparison
   // -------------------------------------------------------------
   task automatic complete_run();
      $display("errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge core_clk);
      bus.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge core_clk);
      bus.rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic st(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] s;
      rd(URPS_OFS_STATUS, s);
      chk(s & m, e);
   endtask

   // Seen is copied at the call: call only once the outputs have settled
   task automatic bit_is(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask

   task automatic clr();
      wr(URPS_OFS_STATUS, ALLC);
   endtask

   // -------------------------------------------------------------
   // Hang guard
   // -------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      complete_run();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      reset       = 1'b1;
      bus         = '0;
      hc          = '0;
      hc.power_on = 1'b1;
      plugged     = 1'b0;
      fault       = 1'b0;
      wake        = 1'b0;
      n_errors    = 0;
      checks_done = 0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      st(ALL, 32'h0);
      rd(URPS_OFS_MASK, v);
      chk(v, 32'h0);
      rd(URPS_OFS_CONFIG, v);
      chk(v, 32'h0);
      rd(4'hC, v);
      chk(v, 32'h0);
      // Enable and suspend requests on an empty port are refused
      wr(URPS_OFS_STATUS, EN);
      st(ALL, CHC);
      clr();
      wr(URPS_OFS_STATUS, SUS);
      st(ALL, CHC);
      clr();
      plugged <= 1'b1;
      settle();
      st(ALL, CON | CHC);
      clr();
      wr(URPS_OFS_STATUS, 32'h0);
      st(ALL, CON);
      wr(URPS_OFS_STATUS, EN);
      st(ALL, CON | EN);
      bit_is(port_enabled, 1'b1);
      wr(URPS_OFS_STATUS, CON);
      st(ALL, CON);
      // Suspend, drop enable, then resume from software
      wr(URPS_OFS_STATUS, EN);
      wr(URPS_OFS_STATUS, SUS);
      st(ALL, CON | EN | SUS);
      bit_is(port_suspend, 1'b1);
      wr(URPS_OFS_STATUS, CON);
      wr(URPS_OFS_STATUS, RSM);
      st(SUS, SUS);
      bit_is(resume_drive, 1'b1);
      repeat (RES + 4) @(posedge core_clk);
      st(ALL, CON | EN | CHS);
      bit_is(resume_drive, 1'b0);
      clr();
      // Remote wakeup from the device
      wr(URPS_OFS_STATUS, SUS);
      wake <= 1'b1;
      for (int i = 0; i <= 40; i++) begin
         if (i == 40) begin
            n_errors++;
            $display("MISMATCH %0t no resume forwarded", $time);
            complete_run();
         end
         @(posedge core_clk);
         #1;
         if (resume_to_hc === 1'b1) break;
      end
      chk({31'h0, resume_drive}, 32'h1);
      @(posedge core_clk);
      wake <= 1'b0;
      repeat (RES + 4) @(posedge core_clk);
      st(SUS | CHS, CHS);
      clr();
      // Port reset completion ends suspend and re-enables
      wr(URPS_OFS_STATUS, SUS);
      wr(URPS_OFS_STATUS, CON);
      @(posedge core_clk);
      hc.reset_done <= 1'b1;
      @(posedge core_clk);
      hc.reset_done <= 1'b0;
      st(ALL, CON | EN | CHR);
      clr();
      wr(URPS_OFS_STATUS, SUS);
      @(posedge core_clk);
      hc.host_resume_state <= 1'b1;
      repeat (2) @(posedge core_clk);
      st(SUS, 32'h0);
      @(posedge core_clk);
      hc.host_resume_state <= 1'b0;
      clr();
      // Faults: babble, overcurrent, power off
      for (int k = 0; k < 3; k++) begin
         wr(URPS_OFS_STATUS, EN);
         clr();
         @(posedge core_clk);
         case (k)
            0: hc.babble <= 1'b1;
            1: fault <= 1'b1;
            default: hc.power_on <= 1'b0;
         endcase
         @(posedge core_clk);
         hc.babble <= 1'b0;
         settle();
         st(EN | CHE, CHE);
         @(posedge core_clk);
         fault       <= 1'b0;
         hc.power_on <= 1'b1;
         settle();
         clr();
      end
      // Disconnect while enabled
      wr(URPS_OFS_STATUS, EN);
      clr();
      plugged <= 1'b0;
      settle();
      st(32'h30007, CHC | CHE);
      wr(URPS_OFS_STATUS, SUS);
      wr(URPS_OFS_STATUS, EN);
      st(32'h7, 32'h0);
      // Interrupt: raised, masked, cleared
      wr(URPS_OFS_MASK, ALLC);
      rd(URPS_OFS_MASK, v);
      chk(v & ALLC, ALLC);
      bit_is(irq, 1'b1);
      wr(URPS_OFS_MASK, 32'h0);
      #1;
      bit_is(irq, 1'b0);
      wr(URPS_OFS_MASK, ALLC);
      clr();
      #1;
      bit_is(irq, 1'b0);
      // Non-removable device always reads connected
      wr(URPS_OFS_CONFIG, 32'h1);
      st(CON, CON);
      rd(URPS_OFS_CONFIG, v);
      chk(v, 32'h1);
      wr(URPS_OFS_CONFIG, 32'h0);
      st(CON, 32'h0);
      complete_run();
   end
endmodule

`default_nettype wire
